// >>> eisf_irq_sense.sv
// What this block does
// - Two 8-bit read/write sense-control registers.
// - Sense registers clear on reset and standby.
// - Pair 00 requests on low pin level.
// - Pair 01 falling, 10 rising, 11 both.
// - Flag register clears on reset and standby.
// - Bits 2..0 are flags; 7..3 read zero.
// - Software can only clear flags, never set.
// - Clear needs read-as-one, then write zero.
// - Level mode: exception clears flag if pin high.
// - Edge modes: exception clears flag unless a new edge sets it.
// - Level mode: low pin sets the flag.
// - Edge modes set flag on selected edges.
// - Flags set regardless of enable bits.
// - Detection ignores pin direction setting.
`include "eisf_params.svh"

module eisf_irq_sense
  import eisf_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    ce,
  input  wire logic                    hwStandby,
  input  wire logic [4:0]              address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  input  wire logic [3:0]              byteenable,
  output logic [31:0]                  readdata,
  output logic                         waitrequest,
  input  wire eisf_pkg::eisf_pins_type extRequestPin,
  input  wire eisf_pkg::eisf_pins_type excAck,
  output eisf_pkg::eisf_pins_type      cpuRequest,
  output logic                         irq
);
  import eisf_pkg::*;

  // Software-visible storage.
  logic [7:0]    senseCtrlHighReg;  // Reserved register, stored and read back.
  logic [7:0]    senseCtrlLowReg;   // Three (B,A) sense pairs in bits 5..0.
  eisf_pins_type requestFlagReg;    // Pending request flag per pin.
  eisf_pins_type requestEnableReg;  // Per-pin enable toward the CPU.
  eisf_pins_type intStatus;         // Sticky event bits, write one to clear.
  eisf_pins_type intMask;           // Gates the status bits onto irq.

  // Bookkeeping.
  eisf_pins_type clearArmed;  // Flag was read as one since the last write and has stayed set since.
  logic          busAck;      // High for the cycle that ends a bus access.

  // Signals from the detector.
  eisf_sense_if  sense ();

  // Bus decode.
  wire           busReq      = read | write;
  wire           writeTaken  = write & busAck & byteenable[0];
  wire           readTaken   = read & busAck;
  wire           selHigh     = address == `EISF_OFS_SENSE_HIGH;
  wire           selLow      = address == `EISF_OFS_SENSE_LOW;
  wire           selFlag     = address == `EISF_OFS_REQ_FLAG;
  wire           selEnable   = address == `EISF_OFS_REQ_ENABLE;
  wire           selStatus   = address == `EISF_OFS_INT_STATUS;
  wire           selMask     = address == `EISF_OFS_INT_MASK;
  wire [7:0]     writeByte   = writedata[7:0];

  // Per-pin decisions.
  eisf_pins_type levelMode;   // Pin is in low-level mode.
  eisf_pins_type excClear;    // Exception handling clears the flag.
  eisf_pins_type swClear;     // Software clear that meets the read-first order.
  eisf_pins_type next_flag;   // Flag value for the next cycle.
  eisf_pins_type next_status; // Interrupt status for the next cycle.
  logic [7:0]    readByte;    // Selected register value.

  // Standby acts as a reset for every software-visible register, as a hard reset does; busAck, readdata and the synchronisers see only nrst.
  wire           regReset = !nrst || hwStandby;

  // Pin synchronisation and condition detection live in the child.
  eisf_sense_detect uDetect (
    .clk           (clk),
    .nrst          (nrst),
    .ce            (ce),
    .extRequestPin (extRequestPin),
    .sense         (sense.detect)
  );

  assign sense.senseMode = senseCtrlLowReg[`EISF_SENSE_MSB:0];

  // Level mode is the all-zero pair; any set bit means an edge mode.
  for (genvar n = 0; n < `EISF_PIN_COUNT; n++) begin : gMode
    assign levelMode[n] = senseCtrlLowReg[2*n+1 -: 2] == 2'b00;
  end

  // In level mode the flag only drops if the pin has gone back high,
  // otherwise the still-active level would raise it again at once.
  assign excClear = excAck & ((levelMode & sense.pinLevel)
                              | ~levelMode);

  // A zero written to a flag clears it only if that flag was seen as one
  // by an earlier read; ones written are ignored.
  assign swClear = {3{writeTaken & selFlag}}
                   & ~writeByte[`EISF_FLAG_MSB:0]
                   & clearArmed;

  // A new set condition wins over any clear in the same cycle, so no
  // request is lost; the enable register has no say in setting.
  assign next_flag = sense.setReq
                     | (requestFlagReg & ~(swClear | excClear));

  // Event bits: a rising flag is the event; the set also wins here.
  assign next_status = (sense.setReq & ~requestFlagReg)
                       | (intStatus & ~({3{writeTaken & selStatus}}
                                        & writeByte[`EISF_FLAG_MSB:0]));

  // Read multiplexer; reserved flag bits and unmapped offsets read zero.
  assign readByte =
    selHigh   ? senseCtrlHighReg :
    selLow    ? senseCtrlLowReg :
    selFlag   ? {5'h00, requestFlagReg} :
    selEnable ? {5'h00, requestEnableReg} :
    selStatus ? {5'h00, intStatus} :
    selMask   ? {5'h00, intMask} :
                8'h00;

  // Every access waits exactly one cycle; the slave then answers.
  assign waitrequest = busReq & ~busAck;

  // Request toward the CPU interrupt logic, per pin.
  assign cpuRequest = requestFlagReg & requestEnableReg;

  // Single level interrupt for unmasked events.
  assign irq = |(intStatus & intMask);

  // Access handshake: one wait cycle, then an acknowledge cycle. The
  // acknowledge drops after one cycle even if the master holds the request,
  // so a held request is answered again rather than stuck.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busAck <= 1'b0;
    end else if (ce) begin
      busAck <= busReq & ~busAck;
    end
  end

  // Read data is loaded as the acknowledge rises and stands until the next
  // read access, so the master sees it at the edge where waitrequest is low.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if (ce && read && !busAck) begin
      readdata <= {24'h00_0000, readByte};
    end
  end

  // Sense-control registers; reserved bits are stored as written because
  // software is expected to keep them at zero.
  always_ff @(posedge clk) begin
    if (regReset) begin
      senseCtrlHighReg <= `EISF_RESET_BYTE;
      senseCtrlLowReg  <= `EISF_RESET_BYTE;
    end else if (ce && writeTaken) begin
      if (selHigh) begin
        senseCtrlHighReg <= writeByte;
      end
      if (selLow) begin
        senseCtrlLowReg <= writeByte;
      end
    end
  end

  // Request flags.
  always_ff @(posedge clk) begin
    if (regReset) begin
      requestFlagReg <= 3'h0;
    end else if (ce) begin
      requestFlagReg <= next_flag;
    end
  end

  // Arming for the software clear: a read of the flag register arms each
  // flag that read as one; any write to the register disarms all of them,
  // so a stale read cannot clear a flag set again afterwards.
  always_ff @(posedge clk) begin
    if (regReset) begin
      clearArmed <= 3'h0;
    end else if (ce) begin
      if (writeTaken && selFlag) begin
        clearArmed <= 3'h0;
      end else if (readTaken && selFlag) begin
        clearArmed <= clearArmed | readdata[`EISF_FLAG_MSB:0];
      end else begin
        clearArmed <= clearArmed & requestFlagReg;
      end
    end
  end

  // Enable, status and mask registers.
  always_ff @(posedge clk) begin
    if (regReset) begin
      requestEnableReg <= 3'h0;
      intStatus        <= 3'h0;
      intMask          <= 3'h0;
    end else if (ce) begin
      intStatus <= next_status;
      if (writeTaken && selEnable) begin
        requestEnableReg <= writeByte[`EISF_FLAG_MSB:0];
      end
      if (writeTaken && selMask) begin
        intMask <= writeByte[`EISF_FLAG_MSB:0];
      end
    end
  end
endmodule : eisf_irq_sense

// >>> eisf_params.svh
`ifndef EISF_PARAMS_SVH
`define EISF_PARAMS_SVH

// Number of external request pins handled by the block.
`define EISF_PIN_COUNT       3

// Register byte offsets on the Avalon-MM slave.
`define EISF_OFS_SENSE_HIGH  5'h00
`define EISF_OFS_SENSE_LOW   5'h04
`define EISF_OFS_REQ_FLAG    5'h08
`define EISF_OFS_REQ_ENABLE  5'h0c
`define EISF_OFS_INT_STATUS  5'h10
`define EISF_OFS_INT_MASK    5'h14

// Reset value of the two sense-control registers.
`define EISF_RESET_BYTE      8'h00

// Field positions.
`define EISF_FLAG_MSB        2
`define EISF_SENSE_MSB       5

`endif

// >>> eisf_pkg.sv
// Types shared by the detector and the register block.
package eisf_pkg;

  // Detection mode of one pin, in the order of its (B,A) sense bit pair.
  typedef enum logic [1:0] {
    EISF_SENSE_LOW,
    EISF_SENSE_FALL,
    EISF_SENSE_RISE,
    EISF_SENSE_BOTH
  } eisf_sense_type;

  // Three-pin vector used for pins, flags and pulses.
  typedef logic [2:0] eisf_pins_type;

endpackage : eisf_pkg

// >>> eisf_sense_if.sv
// Carries sense modes to the detector and its findings back.
interface eisf_sense_if;
  import eisf_pkg::*;

  logic [5:0]    senseMode;  // Three (B,A) pairs, pin 0 in the low bits.
  eisf_pins_type setReq;     // One bit per pin: set condition seen this cycle.
  eisf_pins_type pinLevel;   // Synchronised pin levels.

  modport detect (
    input  senseMode,
    output setReq,
    output pinLevel
  );

  modport ctrl (
    output senseMode,
    input  setReq,
    input  pinLevel
  );
endinterface : eisf_sense_if

// >>> eisf_sense_detect.sv
// Synchronises the request pins and finds level and edge conditions.
`include "eisf_params.svh"

module eisf_sense_detect
  import eisf_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           nrst,
  input  wire logic           ce,
  input  wire eisf_pkg::eisf_pins_type extRequestPin,
  eisf_sense_if.detect        sense
);
  import eisf_pkg::*;

  eisf_pins_type syncFirst;  // First stage, read only by the second.
  eisf_pins_type syncPin;    // Second stage, safe to use.
  eisf_pins_type pinPrev;    // Level one cycle earlier, for edges.

  // Decides whether one pin meets its selected condition this cycle.
  function automatic logic meets(input eisf_sense_type mode, input logic now,
                                 input logic was);
    case (mode)
      EISF_SENSE_LOW:  meets = ~now;
      EISF_SENSE_FALL: meets = was & ~now;
      EISF_SENSE_RISE: meets = ~was & now;
      EISF_SENSE_BOTH: meets = was ^ now;
      default:         meets = 1'b0;
    endcase
  endfunction

  // Two flip-flops before any logic looks at a pin; the previous level starts
  // high so that no edge is invented just after reset.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      syncFirst <= 3'h7;
      syncPin   <= 3'h7;
      pinPrev   <= 3'h7;
    end else if (ce) begin
      syncFirst <= extRequestPin;
      syncPin   <= syncFirst;
      pinPrev   <= syncPin;
    end
  end

  // One detector per pin; the pin direction plays no part here.
  for (genvar n = 0; n < `EISF_PIN_COUNT; n++) begin : gPin
    assign sense.setReq[n] = meets(eisf_sense_type'(sense.senseMode[2*n+1 -: 2]),
                                   syncPin[n], pinPrev[n]);
  end

  assign sense.pinLevel = syncPin;
endmodule : eisf_sense_detect

// >>> eisf_irq_sense_monitor.sv
// Watches the top ports and checks flag, enable and standby behaviour of pin 0.
module eisf_irq_sense_monitor
  import eisf_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic                    ce,
  input wire logic                    hwStandby,
  input wire logic [4:0]              address,
  input wire logic                    read,
  input wire logic                    write,
  input wire logic [31:0]             writedata,
  input wire logic [3:0]              byteenable,
  input wire logic [31:0]             readdata,
  input wire logic                    waitrequest,
  input wire eisf_pkg::eisf_pins_type extRequestPin,
  input wire eisf_pkg::eisf_pins_type excAck,
  input wire eisf_pkg::eisf_pins_type cpuRequest,
  input wire logic                    irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [1:0]    mode0;  // Shadow of the pin 0 sense pair.
  eisf_pins_type en;     // Shadow of the request enable register.
  logic [2:0]    age;    // Edges since reset, so stale synchroniser values are skipped.
  logic          take, lvl0, fall0, rise0;
  assign take  = ce && write && !waitrequest && byteenable[0];
  assign lvl0  = mode0 == 2'h0;
  assign fall0 = mode0[0];
  assign rise0 = mode0[1];
  // Shadows follow accepted writes, as the registers do.
  always_ff @(posedge clk) begin
    if (!nrst || hwStandby) begin
      mode0 <= 2'h0;
      en    <= 3'h0;
    end else if (take && address == 5'h04) begin
      mode0 <= writedata[1:0];
    end else if (take && address == 5'h0c) begin
      en <= writedata[2:0];
    end
  end
  // Saturating age counter.
  always_ff @(posedge clk) begin
    if (!nrst) age <= 3'h0;
    else if (ce && !age[2]) age <= age + 3'h1;
  end
  property p_stby; hwStandby && ce |=> cpuRequest == 3'h0 && !irq; endproperty
  a_stby: assert property (p_stby)
    else $error("request left after standby");
  property p_resv; ce && read && !waitrequest && address == 5'h08 |-> readdata[7:3] == 5'h0;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved flag bits not zero");
  property p_en; (cpuRequest & ~en) == 3'h0; endproperty
  a_en: assert property (p_en)
    else $error("request without enable");
  property p_lvl; (ce && !hwStandby && lvl0 && en[0] && !extRequestPin[0])[*3] |=> cpuRequest[0];
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("low level did not set flag");
  property p_rise; ce && rise0 && en[0] && age[2] && !extRequestPin[0]
    ##1 (ce && !hwStandby && rise0 && en[0] && extRequestPin[0])[*3] |=> cpuRequest[0];
  endproperty
  a_rise: assert property (p_rise)
    else $error("rising edge missed");
  property p_fall; ce && fall0 && en[0] && age[2] && extRequestPin[0]
    ##1 (ce && !hwStandby && fall0 && en[0] && !extRequestPin[0])[*3] |=> cpuRequest[0];
  endproperty
  a_fall: assert property (p_fall)
    else $error("falling edge missed");
  property p_eclr; (ce && $stable(extRequestPin[0]))[*3] ##0 (age[2] && !lvl0 && excAck[0])
    |=> !cpuRequest[0];
  endproperty
  a_eclr: assert property (p_eclr)
    else $error("edge flag not cleared by exception");
  property p_lclr; (ce && extRequestPin[0])[*3] ##0 (age[2] && lvl0 && excAck[0])
    |=> !cpuRequest[0];
  endproperty
  a_lclr: assert property (p_lclr)
    else $error("level flag not cleared by exception");
endmodule // eisf_irq_sense_monitor

bind eisf_irq_sense eisf_irq_sense_monitor eisf_irq_sense_monitor_inst (.clk, .nrst, .ce,
  .hwStandby, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
  .extRequestPin, .excAck, .cpuRequest, .irq);

// >>> eisf_cpu_model.sv
// Stands in for the processor: runs exception handling for pending enabled requests.
module eisf_cpu_model
  import eisf_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire eisf_pkg::eisf_pins_type cpuRequest,
  input wire eisf_pkg::eisf_pins_type ackEnable,
  input wire logic [3:0]              ackDelay,
  output eisf_pkg::eisf_pins_type     excAck
);
  logic [3:0]    waitCnt;  // Latency before the handler starts, prompt or slow.
  eisf_pins_type pend;     // Requests this model will serve.
  assign pend = cpuRequest & ackEnable;
  initial excAck = 3'h0;
  // One pulse per handler entry, lowest pin first; a gap follows each pulse.
  always @(posedge clk) begin
    excAck <= 3'h0;
    if (!nrst || pend == 3'h0 || excAck != 3'h0) waitCnt <= 4'h0;
    else if (waitCnt < ackDelay) waitCnt <= waitCnt + 4'h1;
    else excAck <= pend & (~pend + 3'h1);
  end
endmodule // eisf_cpu_model

// >>> eisf_irq_sense_test.sv
// Register-level test of the request flag block.
module eisf_irq_sense_test
  import eisf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk = 1'b0, nrst = 1'b0, ce = 1'b1, hwStandby = 1'b0;
  logic          read = 1'b0, write = 1'b0, waitrequest, irq;
  logic [4:0]    address = 5'h00;
  logic [31:0]   writedata = 32'h0, readdata, q;
  logic [3:0]    byteenable = 4'hf, ackDelay = 4'h0;
  eisf_pins_type pins = 3'h7, excAck, cpuRequest, ackEnable = 3'h0;
  int            err_total = 0, checks = 0;
  always #2.5 clk = ~clk;
  eisf_irq_sense eisf_irq_sense_inst (.clk, .nrst, .ce, .hwStandby, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .extRequestPin(pins), .excAck,
    .cpuRequest, .irq);
  eisf_cpu_model eisf_cpu_model_inst (.clk, .nrst, .cpuRequest, .ackEnable, .ackDelay, .excAck);
  // Prints the verdict and stops.
  task automatic close_out;
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bus cycle; request held until waitrequest is seen low, then one idle edge.
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    q = readdata;
    if (waitrequest !== 1'b0) begin
      err_total++;
      close_out;
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(a, 1'b0, 8'h00);
    cmp(q, e);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) rd(5'(4 * i), 32'h0);
    rd(5'h1c, 32'h0);
    wr(5'h04, 8'h3f);
    rd(5'h04, 32'h3f);
    byteenable <= 4'h0;
    wr(5'h04, 8'h00);
    byteenable <= 4'hf;
    rd(5'h04, 32'h3f);
    wr(5'h04, 8'h00);
    wr(5'h00, 8'h00);
    rd(5'h00, 32'h0);
    // Level mode with only pin 0 enabled: both low pins still flag.
    wr(5'h0c, 8'h01);
    pins <= 3'h4;
    tick(4);
    rd(5'h08, 32'h3);
    cmp(32'(cpuRequest), 32'h1);
    pins <= 3'h7;
    tick(4);
    wr(5'h08, 8'hff);
    wr(5'h08, 8'h00);
    rd(5'h08, 32'h3);
    wr(5'h08, 8'h01);
    rd(5'h08, 32'h1);
    // Sticky status, mask and write-one-to-clear.
    rd(5'h10, 32'h3);
    wr(5'h14, 8'h01);
    cmp(32'(irq), 32'h1);
    wr(5'h10, 8'h01);
    rd(5'h10, 32'h2);
    cmp(32'(irq), 32'h0);
    wr(5'h10, 8'h02);
    ackEnable <= 3'h7;
    tick(8);
    rd(5'h08, 32'h0);
    pins <= 3'h6;
    tick(8);
    rd(5'h08, 32'h1);
    pins <= 3'h7;
    ackDelay <= 4'h3;
    tick(12);
    rd(5'h08, 32'h0);
    ackEnable <= 3'h0;
    // Every edge mode on all three pins.
    wr(5'h0c, 8'h07);
    for (int m = 1; m < 4; m++) begin
      wr(5'h04, {2'h0, 2'(m), 2'(m), 2'(m)});
      pins <= 3'h0;
      tick(4);
      rd(5'h08, m[0] ? 32'h7 : 32'h0);
      wr(5'h08, 8'h00);
      pins <= 3'h7;
      tick(4);
      rd(5'h08, m[1] ? 32'h7 : 32'h0);
      wr(5'h08, 8'h00);
    end
    pins <= 3'h0;
    tick(4);
    ackDelay <= 4'h0;
    ackEnable <= 3'h7;
    tick(12);
    rd(5'h08, 32'h0);
    ackEnable <= 3'h0;
    wr(5'h04, 8'h2a);
    pins <= 3'h7;
    tick(4);
    hwStandby <= 1'b1;
    tick(2);
    hwStandby <= 1'b0;
    rd(5'h04, 32'h0);
    rd(5'h08, 32'h0);
    rd(5'h10, 32'h0);
    close_out;
  end
endmodule // eisf_irq_sense_test
